/* hdl/pixel_tone_map.vh */
`ifndef PIXEL_TONE_MAP_VH
`define PIXEL_TONE_MAP_VH

// Register byte offsets
`define A_CTRL    6'h00
`define A_GAIN    6'h04
`define A_BLACK   6'h08
`define A_BLKRD   6'h0C
`define A_WBR     6'h10
`define A_WBB     6'h14
`define A_GAMMA   6'h18
`define A_SHARP   6'h1C
`define A_PRESET  6'h20
`define A_STATUS  6'h24

// Control, sharpening and black readback register fields
`define C_GAMMA   0
`define C_SHARP   1
`define C_SAUTO   2
`define C_CLAMP   3
`define C_GAUTO   5:4
`define C_WAUTO   7:6
`define F_AMT     8:0
`define F_THR     27:16
`define F_ANA     11:0
`define F_DIG     27:16

// Auto modes
`define M_OFF     2'h0
`define M_ONCE    2'h1

// Reset values and limits
`define FULL      12'hFFF
`define GAIN_MAX  6'h2F
`define RATIO_ONE 12'h100
`define RATIO_MIN 12'h040
`define RATIO_MAX 12'hFFF
`define WB_STEP   12'h004
`define WB_ITER   4'h7
`define WB_TOL_SH 6
`define GAMMA_ONE 8'h40
`define AMT_DEF   9'h020
`define AMT_MAX   9'h080
`define AMT_MIN   9'h1F0
`define THR_DEF   12'h040
`define THR_MAX   12'h400
`define THR_BASE  12'h010
`define THR_STEP  6'h08
`define BLK_ANA   12'h0FF
`define BLK_SCALE 8'h29
`define AG_LOW    12'hC00
`define AG_HIGH   12'hFF0
`define DIV6_MUL  8'h2B
`define LOG_TOP   13'h0C00
`define EXP_ONE   10'h200
`define EXP_LIM   7'h0D

// Illuminant presets: {red ratio, blue ratio}
`define PRE0      24'h100100
`define PRE1      24'h1801A0
`define PRE2      24'h0E02C0
`define PRE3      24'h150200

`endif

/* hdl/pixel_tone_color_processing.v */
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "pixel_tone_map.vh"

module pixel_tone_color_processing (
  input  wire        CORE_CLK,
  input  wire        RST_N,
  input  wire        CE,
  input  wire [5:0]  ADDRESS,
  input  wire        READ,
  input  wire        WRITE,
  input  wire [31:0] WRITEDATA,
  input  wire [3:0]  BYTEENABLE,
  output reg  [31:0] READDATA,
  output reg         WAITREQUEST,
  input  wire        PIX_VALID,
  input  wire        PIX_SOF,
  input  wire        PIX_EOF,
  input  wire [11:0] PIX_R,
  input  wire [11:0] PIX_G,
  input  wire [11:0] PIX_B,
  input  wire        ROLLING_SHUTTER,
  output reg         PIX_OUT_VALID,
  output reg         PIX_OUT_SOF,
  output reg         PIX_OUT_EOF,
  output reg  [11:0] PIX_OUT_R,
  output reg  [11:0] PIX_OUT_G,
  output reg  [11:0] PIX_OUT_B,
  output reg  [11:0] ANA_OFFSET,
  output reg         CLAMP_EN,
  output reg  [1:0]  CCM_SEL
);

////////////////////////////////////////////////////////////////////////////////

function [31:0] merge;
  input [31:0] old_w;
  input [31:0] new_w;
  input [3:0]  be;
  integer i;
  begin
    for (i = 0; i < 4; i = i + 1) begin
      merge[i*8 +: 8] = be[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
    end
  end
endfunction

function [3:0] msb12;
  input [11:0] v;
  integer i;
  begin
    msb12 = 4'h0;
    for (i = 0; i < 12; i = i + 1) begin
      if (v[i]) begin
        msb12 = i[3:0];
      end
    end
  end
endfunction

function [8:0] clamp_amt;
  input [8:0] v;
  begin
    if (v[8] && v < `AMT_MIN) begin
      clamp_amt = `AMT_MIN;
    end else if (!v[8] && v > `AMT_MAX) begin
      clamp_amt = `AMT_MAX;
    end else begin
      clamp_amt = v;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg        gamma_on_q;
reg        sharp_on_q;
reg        sharp_auto_q;
reg        clamp_on_q;
reg [1:0]  gain_mode_q;
reg [1:0]  wb_mode_q;
reg [5:0]  gain_db_q;
reg [15:0] black_q;
reg [11:0] ratio_r_q;
reg [11:0] ratio_b_q;
reg [7:0]  gamma_q;
reg [8:0]  amt_q;
reg [11:0] thr_q;
reg [3:0]  wb_iter_q;
reg        in_frame_q;
reg [11:0] peak_q;
reg [35:0] sum_r_q;
reg [35:0] sum_g_q;
reg [35:0] sum_b_q;
reg        v1_q;
reg        sof1_q;
reg        eof1_q;
reg        v2_q;
reg        sof2_q;
reg        eof2_q;
reg        sh_gamma_on_q;
reg        sh_sharp_on_q;
reg [7:0]  sh_gamma_q;
reg [8:0]  sh_amt_q;
reg [11:0] sh_thr_q;
reg [11:0] sh_dig_q;
reg [83:0] sh_gain_q;
reg [31:0] rd;

wire [35:0] in_pix = {PIX_R, PIX_G, PIX_B};
wire [35:0] s1_all;
wire [35:0] out_all;
wire        wr_go = WRITE && !WAITREQUEST;
wire        load_sh = !in_frame_q && !(PIX_VALID && PIX_SOF);
wire        frame_end = v1_q && eof1_q;

////////////////////////////////////////////////////////////////////////////////
// Gain in dB to linear Q8: whole 6 dB steps shift, remainder from table

wire [13:0] db_x = gain_db_q * `DIV6_MUL;
wire [2:0]  db_q6 = db_x[10:8];
wire [5:0]  db_six = {db_q6, 1'b0} + {1'b0, db_q6, 1'b0} + {1'b0, db_q6, 1'b0};
wire [5:0]  db_rem = gain_db_q - db_six;
reg  [8:0]  db_frac;

always @* begin
  case (db_rem[2:0])
    3'h0:    db_frac = 9'h100;
    3'h1:    db_frac = 9'h11F;
    3'h2:    db_frac = 9'h143;
    3'h3:    db_frac = 9'h16A;
    3'h4:    db_frac = 9'h196;
    default: db_frac = 9'h1C8;
  endcase
end

wire [15:0] gain_lin = {7'h00, db_frac} << db_q6;
wire [27:0] gain_r = gain_lin * ratio_r_q;
wire [27:0] gain_g = gain_lin * `RATIO_ONE;
wire [27:0] gain_b = gain_lin * ratio_b_q;

////////////////////////////////////////////////////////////////////////////////
// Black level split and sharpening threshold

wire [23:0] blk_x = black_q * `BLK_SCALE;
wire [11:0] blk_code = |blk_x[23:20] ? `FULL : blk_x[19:8];
wire [11:0] blk_ana = (blk_code > `BLK_ANA) ? `BLK_ANA : blk_code;
wire [11:0] blk_dig = blk_code - blk_ana;
wire [11:0] thr_auto = `THR_BASE + gain_db_q * `THR_STEP;
wire [11:0] thr_raw = sharp_auto_q ? thr_auto : thr_q;
wire [11:0] thr_eff = (thr_raw > `THR_MAX) ? `THR_MAX : thr_raw;

////////////////////////////////////////////////////////////////////////////////
// Frame statistics taken after gain and white balance

wire [11:0] s1_r = s1_all[35:24];
wire [11:0] s1_g = s1_all[23:12];
wire [11:0] s1_b = s1_all[11:0];
wire [11:0] peak_n = (sof1_q || s1_g > peak_q) ? s1_g : peak_q;
wire [35:0] sum_r_n = (sof1_q ? 36'h0 : sum_r_q) + s1_r;
wire [35:0] sum_g_n = (sof1_q ? 36'h0 : sum_g_q) + s1_g;
wire [35:0] sum_b_n = (sof1_q ? 36'h0 : sum_b_q) + s1_b;
wire [35:0] cmp_r = sum_r_n >> `WB_TOL_SH;
wire [35:0] cmp_g = sum_g_n >> `WB_TOL_SH;
wire [35:0] cmp_b = sum_b_n >> `WB_TOL_SH;

////////////////////////////////////////////////////////////////////////////////
// Register read mux

always @* begin
  rd = 32'h0;
  case (ADDRESS)
    `A_CTRL:   rd[7:0] = {wb_mode_q, gain_mode_q, clamp_on_q, sharp_auto_q,
                          sharp_on_q, gamma_on_q};
    `A_GAIN:   rd[5:0] = gain_db_q;
    `A_BLACK:  rd[15:0] = black_q;
    `A_BLKRD:  rd = {4'h0, blk_dig, 4'h0, blk_ana};
    `A_WBR:    rd[11:0] = ratio_r_q;
    `A_WBB:    rd[11:0] = ratio_b_q;
    `A_GAMMA:  rd[7:0] = gamma_q;
    `A_SHARP:  rd = {4'h0, thr_eff, 7'h00, amt_q};
    `A_PRESET: rd[1:0] = CCM_SEL;
    `A_STATUS: rd = {4'h0, peak_q, 8'h00, wb_iter_q, 3'h0, in_frame_q};
    default:   rd = 32'h0;
  endcase
end

wire [31:0] wd = merge(rd, WRITEDATA, BYTEENABLE);

// One wait state per access; idle waitrequest stays high
always @(posedge CORE_CLK or negedge RST_N) begin
  if (!RST_N) begin
    WAITREQUEST <= 1'b1;
    READDATA    <= 32'h0;
  end else if (CE) begin
    if (WAITREQUEST) begin
      if (READ || WRITE) begin
        WAITREQUEST <= 1'b0;
        READDATA    <= READ ? rd : 32'h0;
      end
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers; software writes land after auto updates so they win

always @(posedge CORE_CLK or negedge RST_N) begin
  if (!RST_N) begin
    gamma_on_q   <= 1'b0;
    sharp_on_q   <= 1'b0;
    sharp_auto_q <= 1'b0;
    clamp_on_q   <= 1'b0;
    gain_mode_q  <= `M_OFF;
    wb_mode_q    <= `M_OFF;
    gain_db_q    <= 6'h00;
    black_q      <= 16'h0000;
    ratio_r_q    <= `RATIO_ONE;
    ratio_b_q    <= `RATIO_ONE;
    gamma_q      <= `GAMMA_ONE;
    amt_q        <= `AMT_DEF;
    thr_q        <= `THR_DEF;
    wb_iter_q    <= 4'h0;
    CCM_SEL      <= 2'h0;
  end else if (CE) begin
    if (frame_end && gain_mode_q != `M_OFF) begin
      if (peak_n < `AG_LOW && gain_db_q < `GAIN_MAX) begin
        gain_db_q <= gain_db_q + 6'h01;
      end else if (peak_n >= `AG_HIGH && gain_db_q != 6'h00) begin
        gain_db_q <= gain_db_q - 6'h01;
      end
      if (gain_mode_q == `M_ONCE) begin
        gain_mode_q <= `M_OFF;
      end
    end
    if (frame_end && wb_mode_q != `M_OFF) begin
      if (cmp_r < cmp_g && ratio_r_q < `RATIO_MAX - `WB_STEP) begin
        ratio_r_q <= ratio_r_q + `WB_STEP;
      end else if (cmp_r > cmp_g && ratio_r_q > `RATIO_MIN + `WB_STEP) begin
        ratio_r_q <= ratio_r_q - `WB_STEP;
      end
      if (cmp_b < cmp_g && ratio_b_q < `RATIO_MAX - `WB_STEP) begin
        ratio_b_q <= ratio_b_q + `WB_STEP;
      end else if (cmp_b > cmp_g && ratio_b_q > `RATIO_MIN + `WB_STEP) begin
        ratio_b_q <= ratio_b_q - `WB_STEP;
      end
      if (wb_mode_q == `M_ONCE) begin
        if (wb_iter_q == `WB_ITER) begin
          wb_mode_q <= `M_OFF;
          wb_iter_q <= 4'h0;
        end else begin
          wb_iter_q <= wb_iter_q + 4'h1;
        end
      end
    end
    if (wr_go) begin
      case (ADDRESS)
        `A_CTRL: begin
          gamma_on_q   <= wd[`C_GAMMA];
          sharp_on_q   <= wd[`C_SHARP];
          sharp_auto_q <= wd[`C_SAUTO];
          clamp_on_q   <= wd[`C_CLAMP];
          gain_mode_q  <= wd[`C_GAUTO];
          wb_mode_q    <= wd[`C_WAUTO];
          wb_iter_q    <= 4'h0;
        end
        `A_GAIN:  gain_db_q <= (wd[5:0] > `GAIN_MAX) ? `GAIN_MAX : wd[5:0];
        `A_BLACK: black_q <= wd[15:0];
        `A_WBR:   ratio_r_q <= wd[11:0];
        `A_WBB:   ratio_b_q <= wd[11:0];
        `A_GAMMA: gamma_q <= wd[7:0];
        `A_SHARP: begin
          amt_q <= clamp_amt(wd[`F_AMT]);
          thr_q <= wd[`F_THR];
        end
        `A_PRESET: begin
          CCM_SEL <= wd[1:0];
          case (wd[1:0])
            2'h0:    {ratio_r_q, ratio_b_q} <= `PRE0;
            2'h1:    {ratio_r_q, ratio_b_q} <= `PRE1;
            2'h2:    {ratio_r_q, ratio_b_q} <= `PRE2;
            default: {ratio_r_q, ratio_b_q} <= `PRE3;
          endcase
        end
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Frame tracking, shadow settings, stats and stream control

always @(posedge CORE_CLK or negedge RST_N) begin
  if (!RST_N) begin
    in_frame_q    <= 1'b0;
    peak_q        <= 12'h000;
    sum_r_q       <= 36'h0;
    sum_g_q       <= 36'h0;
    sum_b_q       <= 36'h0;
    {v1_q, sof1_q, eof1_q, v2_q, sof2_q, eof2_q} <= 6'h00;
    {PIX_OUT_VALID, PIX_OUT_SOF, PIX_OUT_EOF} <= 3'h0;
    sh_gamma_on_q <= 1'b0;
    sh_sharp_on_q <= 1'b0;
    sh_gamma_q    <= `GAMMA_ONE;
    sh_amt_q      <= `AMT_DEF;
    sh_thr_q      <= `THR_DEF;
    sh_dig_q      <= 12'h000;
    sh_gain_q     <= 84'h0;
    ANA_OFFSET    <= 12'h000;
    CLAMP_EN      <= 1'b0;
  end else if (CE) begin
    if (PIX_VALID && PIX_SOF) begin
      in_frame_q <= 1'b1;
    end else if (PIX_VALID && PIX_EOF) begin
      in_frame_q <= 1'b0;
    end
    // Mid-frame writes are held off to avoid torn frames
    if (load_sh) begin
      sh_gamma_on_q <= gamma_on_q;
      sh_sharp_on_q <= sharp_on_q;
      sh_gamma_q    <= gamma_q;
      sh_amt_q      <= amt_q;
      sh_thr_q      <= thr_eff;
      sh_dig_q      <= blk_dig;
      sh_gain_q     <= {gain_r, gain_g, gain_b};
      ANA_OFFSET    <= blk_ana;
    end
    CLAMP_EN <= clamp_on_q && !ROLLING_SHUTTER;
    if (v1_q) begin
      peak_q  <= peak_n;
      sum_r_q <= sum_r_n;
      sum_g_q <= sum_g_n;
      sum_b_q <= sum_b_n;
    end
    {v1_q, sof1_q, eof1_q} <= {PIX_VALID, PIX_VALID && PIX_SOF, PIX_VALID && PIX_EOF};
    {v2_q, sof2_q, eof2_q} <= {v1_q, sof1_q, eof1_q};
    {PIX_OUT_VALID, PIX_OUT_SOF, PIX_OUT_EOF} <= {v2_q, sof2_q, eof2_q};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel datapath: gain/balance/black, gamma, sharpen

genvar c;
generate
  for (c = 0; c < 3; c = c + 1) begin : ch
    reg  [11:0] s1;
    reg  [11:0] s2;
    reg  [11:0] prev;
    wire [39:0] prod = in_pix[c*12 +: 12] * sh_gain_q[c*28 +: 28];
    wire [11:0] sat = |prod[39:28] ? `FULL : prod[27:16];
    wire [11:0] blk = (sat > sh_dig_q) ? sat - sh_dig_q : 12'h000;
    // Log/exp approximation keeps gamma to one small multiplier
    wire [3:0]  m = msb12(s1);
    wire [11:0] nrm = s1 << (4'hB - m);
    wire [12:0] dlog = `LOG_TOP - {1'b0, m, nrm[10:3]};
    wire [20:0] ex = dlog * sh_gamma_q;
    wire [9:0]  mant = `EXP_ONE - {2'h0, ex[13:6]};
    wire [12:0] pw = {mant, 3'h0} >> ex[20:14];
    wire [11:0] gam = (s1 == 12'h000 || ex[20:14] >= `EXP_LIM) ? 12'h000 :
                      (pw[12] ? `FULL : pw[11:0]);
    wire signed [12:0] df = $signed({1'b0, s2}) - $signed({1'b0, prev});
    wire [12:0] mag = df[12] ? 13'h0 - df : df;
    wire signed [21:0] amp = df * $signed(sh_amt_q);
    wire signed [21:0] sum = $signed({10'h000, s2}) + (amp >>> 4);
    wire [11:0] shp = sum[21] ? 12'h000 : (|sum[20:12] ? `FULL : sum[11:0]);
    wire        use_shp = sh_sharp_on_q && !sof2_q && (mag > {1'b0, sh_thr_q});

    assign s1_all[c*12 +: 12] = s1;
    assign out_all[c*12 +: 12] = use_shp ? shp : s2;

    always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        s1   <= 12'h000;
        s2   <= 12'h000;
        prev <= 12'h000;
      end else if (CE) begin
        s1 <= blk;
        s2 <= sh_gamma_on_q ? gam : s1;
        if (v2_q) begin
          prev <= s2;
        end
      end
    end
  end
endgenerate

// Sharpened or s2 result (gamma or linear) drives the pixel outputs from these registers
always @(posedge CORE_CLK or negedge RST_N) begin
  if (!RST_N) begin
    PIX_OUT_R <= 12'h000;
    PIX_OUT_G <= 12'h000;
    PIX_OUT_B <= 12'h000;
  end else if (CE) begin
    PIX_OUT_R <= out_all[35:24];
    PIX_OUT_G <= out_all[23:12];
    PIX_OUT_B <= out_all[11:0];
  end
end

endmodule

/* testbench/pixel_sensor_model.sv */
`timescale 1ns/1ps
module pixel_sensor_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        go,
  input  wire [11:0] mask,
  output reg         valid,
  output reg         sof,
  output reg         eof,
  output reg  [11:0] r,
  output reg  [11:0] g,
  output reg  [11:0] b,
  output reg         busy
);
  reg     [15:0] lfsr;
  integer        n;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= 16'hACE1;
      {valid, sof, eof, busy, r, g, b} <= 40'h0;
      n <= 0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (go && !busy) begin
        busy <= 1'b1;
        n <= 0;
      end
      // Idle lines keep changing so no stale value looks valid
      {valid, sof, eof} <= 3'h0;
      r <= ~lfsr[11:0];
      g <= lfsr[15:4];
      b <= lfsr[11:0] ^ 12'hA5A;
      if (busy && lfsr[0]) begin
        valid <= 1'b1;
        sof <= (n == 0);
        eof <= (n == 15);
        r <= lfsr[11:0] & mask;
        g <= lfsr[15:4] & mask;
        b <= lfsr[13:2] & mask;
        n <= n + 1;
        if (n == 15) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule

/* testbench/pixel_tone_color_processing_props.sv */
`timescale 1ns/1ps
module pixel_tone_checker (
  input wire        CORE_CLK,
  input wire        RST_N,
  input wire        CE,
  input wire        READ,
  input wire        WRITE,
  input wire        WAITREQUEST,
  input wire [31:0] READDATA,
  input wire        PIX_VALID,
  input wire        PIX_SOF,
  input wire        PIX_EOF,
  input wire        PIX_OUT_VALID,
  input wire        PIX_OUT_SOF,
  input wire        PIX_OUT_EOF,
  input wire        ROLLING_SHUTTER,
  input wire        CLAMP_EN,
  input wire [11:0] ANA_OFFSET
);
  reg frm_q;
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      frm_q <= 1'b0;
    end else if (PIX_VALID && PIX_SOF) begin
      frm_q <= 1'b1;
    end else if (PIX_VALID && PIX_EOF) begin
      frm_q <= 1'b0;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_ack_one; !WAITREQUEST |=> WAITREQUEST; endproperty
  a_ack_one: assert property (p_ack_one) else $error("wait request low over one cycle");
  property p_ack; (READ || WRITE) && WAITREQUEST && CE |=> !WAITREQUEST; endproperty
  a_ack: assert property (p_ack) else $error("access not answered next cycle");
  property p_idle; !READ && !WRITE && WAITREQUEST |=> WAITREQUEST; endproperty
  a_idle: assert property (p_idle) else $error("answer without a request");
  property p_wr_zero; !WAITREQUEST && WRITE |-> READDATA == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
  property p_lat; PIX_OUT_VALID == $past(PIX_VALID, 3); endproperty
  a_lat: assert property (p_lat) else $error("pixel valid latency not three");
  property p_sof; PIX_VALID && PIX_SOF |-> ##3 (PIX_OUT_SOF && PIX_OUT_VALID); endproperty
  a_sof: assert property (p_sof) else $error("frame start not carried");
  property p_eof; PIX_VALID |-> ##3 (PIX_OUT_EOF == $past(PIX_EOF, 3)); endproperty
  a_eof: assert property (p_eof) else $error("frame end not carried");
  property p_clamp; CLAMP_EN |-> !$past(ROLLING_SHUTTER); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp on rolling shutter");
  property p_ana; frm_q && $past(frm_q) |-> $stable(ANA_OFFSET); endproperty
  a_ana: assert property (p_ana) else $error("analog offset moved in frame");
  c_read: cover property (READ && !WAITREQUEST);
  c_write: cover property (WRITE && !WAITREQUEST);
  c_frame: cover property (PIX_OUT_VALID && PIX_OUT_EOF);
  c_clamp: cover property (CLAMP_EN);
endmodule
bind pixel_tone_color_processing pixel_tone_checker i_pixel_tone_checker (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .READ(READ), .WRITE(WRITE),
  .WAITREQUEST(WAITREQUEST), .READDATA(READDATA), .PIX_VALID(PIX_VALID),
  .PIX_SOF(PIX_SOF), .PIX_EOF(PIX_EOF), .PIX_OUT_VALID(PIX_OUT_VALID),
  .PIX_OUT_SOF(PIX_OUT_SOF), .PIX_OUT_EOF(PIX_OUT_EOF),
  .ROLLING_SHUTTER(ROLLING_SHUTTER), .CLAMP_EN(CLAMP_EN), .ANA_OFFSET(ANA_OFFSET));

/* testbench/pixel_tone_color_processing_bench.sv */
`timescale 1ns/1ps
`include "pixel_tone_map.vh"
module pixel_tone_color_processing_bench;
  reg         CORE_CLK = 1'b0;
  reg         RST_N = 1'b0;
  reg  [5:0]  ADDRESS = 6'h00;
  reg         READ = 1'b0;
  reg         WRITE = 1'b0;
  reg  [31:0] WRITEDATA = 32'h0;
  reg         ROLLING_SHUTTER = 1'b0;
  reg         go = 1'b0;
  reg  [11:0] mask = 12'hFFF;
  reg  [3:0]  BYTEENABLE = 4'hF;
  wire [31:0] READDATA;
  wire        WAITREQUEST, PIX_VALID, PIX_SOF, PIX_EOF, busy, CLAMP_EN;
  wire        PIX_OUT_VALID, PIX_OUT_SOF, PIX_OUT_EOF;
  wire [11:0] PIX_R, PIX_G, PIX_B, PIX_OUT_R, PIX_OUT_G, PIX_OUT_B, ANA_OFFSET;
  wire [1:0]  CCM_SEL;
  integer     errors = 0, samples_checked = 0, cycles = 0, tol = 0, scb = 0;
  integer     rat_r = 256, rat_b = 256, dig = 0, shp = 0, amt = 32, thr = 64;
  integer     pr, pg, pb, i, k, ana, gma = 64;
  reg  [31:0] q, v;
  reg  [35:0] e0, e1, e2;
  always #4 CORE_CLK = ~CORE_CLK;
  pixel_tone_color_processing i_pixel_tone_color_processing (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(1'b1), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .PIX_VALID(PIX_VALID), .PIX_SOF(PIX_SOF), .PIX_EOF(PIX_EOF),
    .PIX_R(PIX_R), .PIX_G(PIX_G), .PIX_B(PIX_B), .ROLLING_SHUTTER(ROLLING_SHUTTER),
    .PIX_OUT_VALID(PIX_OUT_VALID), .PIX_OUT_SOF(PIX_OUT_SOF), .PIX_OUT_EOF(PIX_OUT_EOF),
    .PIX_OUT_R(PIX_OUT_R), .PIX_OUT_G(PIX_OUT_G), .PIX_OUT_B(PIX_OUT_B),
    .ANA_OFFSET(ANA_OFFSET), .CLAMP_EN(CLAMP_EN), .CCM_SEL(CCM_SEL));
  pixel_sensor_model i_pixel_sensor_model (
    .clk(CORE_CLK), .rst_n(RST_N), .go(go), .mask(mask), .valid(PIX_VALID),
    .sof(PIX_SOF), .eof(PIX_EOF), .r(PIX_R), .g(PIX_G), .b(PIX_B), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////////
  // Exact only with neutral scaling while sharpening runs
  function automatic [11:0] ex(input integer c, input integer p, input integer s,
                               input integer r);
    integer x;
    begin
      x = (c * r) >>> 8;
      if (x > 4095) x = 4095;
      x = x - dig;
      if (x < 0) x = 0;
      if (gma != 64 && x > 0) x = $rtoi(4096.0 * ((x / 4096.0) ** (gma / 64.0)));
      if (shp != 0 && s == 0 && (x - p > thr || p - x > thr)) x = x + amt * (x - p) / 16;
      x = (x > 4095) ? 4095 : (x < 0) ? 0 : x;
      ex = x[11:0];
    end
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (!(got === e || (tol > 0 && !$isunknown(got) && got + tol >= e && got <= e + tol))) begin
        errors = errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, got);
      end
    end
  endtask
  task bus(input [5:0] a, input w, input [31:0] d);
    begin
      @(posedge CORE_CLK);
      ADDRESS <= a;
      READ <= !w;
      WRITE <= w;
      WRITEDATA <= d;
      // Look mid-cycle so the edge sample is free of update races
      @(negedge CORE_CLK);
      while (WAITREQUEST !== 1'b0) @(negedge CORE_CLK);
      @(posedge CORE_CLK);
      q = READDATA;
      READ <= 1'b0;
      WRITE <= 1'b0;
    end
  endtask
  task rdc(input string nm, input [5:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk(nm, e, q);
    end
  endtask
  task frame;
    begin
      @(posedge CORE_CLK);
      go <= 1'b1;
      @(posedge CORE_CLK);
      go <= 1'b0;
      @(posedge CORE_CLK);
      while (busy === 1'b1) @(posedge CORE_CLK);
      repeat (8) @(posedge CORE_CLK);
    end
  endtask
  task tend(input string nm);
    $display("test %0s finished, %0d mismatches so far", nm, errors);
  endtask
  task conclude;
    begin
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CORE_CLK) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude;
    end
    if (scb != 0 && PIX_OUT_VALID === 1'b1) begin
      chk("red out", e2[35:24], PIX_OUT_R);
      chk("green out", e2[23:12], PIX_OUT_G);
      chk("blue out", e2[11:0], PIX_OUT_B);
    end
    e2 = e1;
    e1 = e0;
    e0 = {ex(PIX_R, pr, PIX_SOF, rat_r), ex(PIX_G, pg, PIX_SOF, 256), ex(PIX_B, pb, PIX_SOF, rat_b)};
    if (PIX_VALID === 1'b1) begin
      pr = PIX_R;
      pg = PIX_G;
      pb = PIX_B;
    end
  end
  initial begin
    q = $urandom(32'hB6F2D114);
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rdc("ctrl", `A_CTRL, 32'h0);
    rdc("sharp", `A_SHARP, 32'h0040_0020);
    rdc("red ratio", `A_WBR, 32'h100);
    rdc("gamma", `A_GAMMA, 32'h40);
    BYTEENABLE <= 4'h1;
    bus(`A_SHARP, 1'b1, 32'hFFFF_FF10);
    BYTEENABLE <= 4'hF;
    rdc("lane merge", `A_SHARP, 32'h0040_0010);
    bus(6'h3C, 1'b1, 32'hFFFF_FFFF);
    rdc("unmapped", 6'h3C, 32'h0);
    scb = 1;
    frame;
    tend("reset and bypass");
    bus(`A_CTRL, 1'b1, 32'h2);
    shp = 1;
    thr = 256;
    for (i = 0; i < 4; i = i + 1) begin
      amt = (i == 0) ? 32 : (i == 1) ? 0 : (i == 2) ? -16 : 128;
      bus(`A_SHARP, 1'b1, {4'h0, 12'h100, 7'h00, amt[8:0]});
      frame;
    end
    bus(`A_SHARP, 1'b1, {4'h0, 12'hFFF, 7'h00, 9'h0FF});
    rdc("clamped sharp", `A_SHARP, 32'h0400_0080);
    bus(`A_SHARP, 1'b1, {23'h0, 9'h100});
    rdc("smooth floor", `A_SHARP, 32'h0000_01F0);
    bus(`A_CTRL, 1'b1, 32'h0);
    shp = 0;
    tend("sharpening");
    rat_r = 64 + $urandom % 768;
    rat_b = 64 + $urandom % 768;
    v = $urandom & 32'hFFFF;
    k = (v * 41) >> 8;
    if (k > 4095) k = 4095;
    ana = (k > 255) ? 255 : k;
    bus(`A_WBR, 1'b1, rat_r);
    bus(`A_WBB, 1'b1, rat_b);
    bus(`A_BLACK, 1'b1, v);
    dig = k - ana;
    rdc("black parts", `A_BLKRD, (dig << 16) | ana);
    bus(`A_BLKRD, 1'b1, 32'h0);
    rdc("black read only", `A_BLKRD, (dig << 16) | ana);
    frame;
    chk("analog offset", ana, ANA_OFFSET);
    bus(`A_BLACK, 1'b1, 32'h0);
    dig = 0;
    tend("balance and black");
    for (i = 3; i >= 0; i = i - 1) begin
      bus(`A_PRESET, 1'b1, i);
      v = (i == 0) ? `PRE0 : (i == 1) ? `PRE1 : (i == 2) ? `PRE2 : `PRE3;
      rdc("preset red", `A_WBR, v[23:12]);
      rdc("preset blue", `A_WBB, v[11:0]);
      chk("transform select", i, CCM_SEL);
    end
    rat_r = 256;
    rat_b = 256;
    bus(`A_CTRL, 1'b1, 32'h1);
    // Log/exp approximation: coarse tolerance away from unity power
    for (i = 0; i < 2; i = i + 1) begin
      gma = (i == 0) ? 64 : 32;
      tol = (i == 0) ? 9 : 300;
      bus(`A_GAMMA, 1'b1, gma);
      frame;
    end
    bus(`A_GAMMA, 1'b1, 32'h40);
    gma = 64;
    tol = 0;
    tend("presets and power curve");
    bus(`A_CTRL, 1'b1, 32'h8);
    repeat (2) @(posedge CORE_CLK);
    chk("clamp on", 1, CLAMP_EN);
    ROLLING_SHUTTER <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    chk("clamp rolling", 0, CLAMP_EN);
    scb = 0;
    tend("clamping");
    bus(`A_GAIN, 1'b1, 32'd50);
    rdc("gain clamp", `A_GAIN, 32'd47);
    bus(`A_GAIN, 1'b1, 32'd0);
    mask <= 12'h0FF;
    frame;
    rdc("manual gain", `A_GAIN, 32'd0);
    bus(`A_CTRL, 1'b1, 32'h10);
    frame;
    rdc("gain once mode", `A_CTRL, 32'h0);
    rdc("gain once step", `A_GAIN, 32'd1);
    bus(`A_CTRL, 1'b1, 32'h20);
    frame;
    frame;
    rdc("gain cont mode", `A_CTRL, 32'h20);
    rdc("gain cont step", `A_GAIN, 32'd3);
    bus(`A_CTRL, 1'b1, 32'h04);
    rdc("auto threshold", `A_SHARP, 32'h0028_01F0);
    tend("amplification");
    bus(`A_CTRL, 1'b1, 32'h40);
    repeat (7) frame;
    rdc("balance once run", `A_CTRL, 32'h40);
    frame;
    rdc("balance once end", `A_CTRL, 32'h0);
    bus(`A_CTRL, 1'b1, 32'h80);
    frame;
    rdc("balance cont", `A_CTRL, 32'h80);
    tend("auto balance");
    conclude;
  end
endmodule
